/* File: core/lmtc_pkg.sv */
// lmtc_pkg: constants shared by the line mode and termination config block
// assumes: 16 channels, AXI4-Lite register access with a 12-bit byte address
package lmtc_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_CH = 16;
  localparam int AXI_ADDR_W = 12;
  localparam int GLOB_W = 3;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [5:0] REGION_CHAN = 6'h00;
  localparam logic [5:0] REGION_RX = 6'h01;
  localparam logic [5:0] REGION_STAT = 6'h02;
  localparam logic [11:0] CHAN_CFG_BASE = 12'h000;
  localparam logic [11:0] RX_CFG_BASE = 12'h040;
  localparam logic [11:0] STATUS_BASE = 12'h080;
  localparam logic [7:0] CHAN_CFG_RST = 8'h00;
  localparam logic [7:0] RX_CFG_RST = 8'h04;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int LINE_STD_BIT = 0;
  localparam int TERM_LO_BIT = 0;
  localparam int TERM_TOP_BIT = 2;
  localparam int SINGLE_BIT = 3;
  localparam int SCHEME_BIT = 4;
  localparam int ST_E1 = 0;
  localparam int ST_SINGLE = 1;
  localparam int ST_RING = 2;
  localparam int ST_HIGH_Z = 3;
  localparam int ST_INT = 4;
  localparam int ST_FULL = 5;
  localparam int ST_RES_LO = 6;
  // ----------------------------------------
  // global pin positions in the synchronised vector
  // ----------------------------------------
  localparam int PIN_STRAP_EN = 0;
  localparam int PIN_STRAP = 1;
  localparam int PIN_HIGH_Z = 2;
  // ----------------------------------------
  // internal resistor codes and bus answers
  // ----------------------------------------
  localparam logic [1:0] RES_T1_100 = 2'h0;
  localparam logic [1:0] RES_J1_110 = 2'h1;
  localparam logic [1:0] RES_E1_120 = 2'h2;
  localparam logic [1:0] RES_E1_75 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: core/lmtc_chan_if.sv */
// lmtc_chan_if: one channel's configuration bits in, decoded mode out
// assumes: driven by the main block, decoded by lmtc_chan_decode
`timescale 1ns/1ps
interface lmtc_chan_if;
  logic [7:0] chan_cfg;
  logic [7:0] rx_cfg;
  logic strap_en;
  logic strap;
  logic hz_ctl;
  logic e1;
  logic single;
  logic ring_en;
  logic high_z;
  logic int_match;
  logic fully_int;
  logic [1:0] res_code;
  modport ctrl (
    output chan_cfg, rx_cfg, strap_en, strap, hz_ctl,
    input e1, single, ring_en, high_z, int_match, fully_int, res_code
  );
  modport dec (
    input chan_cfg, rx_cfg, strap_en, strap, hz_ctl,
    output e1, single, ring_en, high_z, int_match, fully_int, res_code
  );
endinterface

/* File: core/lmtc_sync.sv */
// lmtc_sync: two flip-flop synchroniser for a vector of pin levels
// assumes: each bit is an independent static level
`timescale 1ns/1ps
module lmtc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= d;
      stage2_reg <= stage1_reg;
    end
  end

  assign q = stage2_reg;
endmodule

/* File: core/lmtc_chan_decode.sv */
// lmtc_chan_decode: combinational mode and termination decode of one channel
// assumes: global pin levels arrive already synchronised
`timescale 1ns/1ps
module lmtc_chan_decode
  import lmtc_pkg::*;
(
  // channel signals
  lmtc_chan_if.dec ch
);
  logic ext_only;

  // open strap enable (high) means one standard for all channels
  assign ch.e1 = ch.strap_en ? !ch.strap : ch.chan_cfg[LINE_STD_BIT];
  assign ch.single = ch.rx_cfg[SINGLE_BIT];
  assign ch.ring_en = !ch.rx_cfg[SINGLE_BIT];
  // low global pin forces external matching, ignoring the channel fields
  assign ext_only = !ch.hz_ctl || ch.rx_cfg[TERM_TOP_BIT];
  assign ch.high_z = ext_only;
  assign ch.int_match = !ext_only;
  // scheme bit set selects partially internal, clear selects fully internal
  assign ch.fully_int = !ext_only && !ch.rx_cfg[SCHEME_BIT];
  assign ch.res_code = ext_only ? RES_T1_100 : ch.rx_cfg[TERM_LO_BIT +: 2];
endmodule

/* File: core/lmtc_top.sv */
// lmtc_top: line standard and receive termination configuration, 16 channels
// assumes: AXI4-Lite master on clk, strap and line pins asynchronous to clk
`timescale 1ns/1ps
// Behaviour
// - with strap enable open, one standard for all: strap open is T1/J1, low is E1.
// - with strap enable low, each channel's standard bit 0 picks T1/J1 (0) or E1 (1).
// - bit 3 of each receive config register picks single-ended or differential input.
// - single-ended input uses the tip only; differential uses both tip and ring.
// - a low global high-z pin forces external matching on all 16 receivers.
// - the global high-z pin reaches all receivers through the two-flop synchroniser and the output register, with no register access.
// - a high global high-z pin lets each channel's own fields choose the matching.
// - termination top bit 0 enables internal matching; bit 4 picks partial or full.
// - under internal matching the low two bits pick 100, 110, 120 or 75 ohm.
// - termination top bit 1 selects external-only matching, inputs in high impedance.
module lmtc_top
  import lmtc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite write address and data
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // global pins, high when open
  input wire logic global_standard_strap_enable,
  input wire logic global_standard_strap,
  input wire logic global_rx_high_z_control,
  // line inputs
  input wire logic [NUM_CH-1:0] rx_tip_input,
  input wire logic [NUM_CH-1:0] rx_ring_input,
  // decoded mode per channel
  output logic [NUM_CH-1:0] line_e1_reg,
  output logic [NUM_CH-1:0] rx_single_reg,
  output logic [NUM_CH-1:0] rx_high_z_reg,
  output logic [NUM_CH-1:0] int_match_reg,
  output logic [NUM_CH-1:0] fully_int_reg,
  output logic [2*NUM_CH-1:0] res_code_reg,
  // received line levels
  output logic [NUM_CH-1:0] rx_tip_out_reg,
  output logic [NUM_CH-1:0] rx_ring_out_reg
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [GLOB_W-1:0] glob_s;
  logic [2*NUM_CH-1:0] line_s;
  logic [7:0] chan_cfg_reg [NUM_CH];
  logic [7:0] rx_cfg_reg [NUM_CH];
  logic [NUM_CH-1:0] dec_e1;
  logic [NUM_CH-1:0] dec_single;
  logic [NUM_CH-1:0] dec_ring;
  logic [NUM_CH-1:0] dec_high_z;
  logic [NUM_CH-1:0] dec_int;
  logic [NUM_CH-1:0] dec_full;
  logic [2*NUM_CH-1:0] dec_res;
  logic aw_hold_reg;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic w_hold_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic [5:0] wr_region;
  logic [3:0] wr_ch;
  logic wr_ok;
  logic [5:0] rd_region;
  logic [3:0] rd_ch;
  logic [31:0] rd_next;
  logic [1:0] rresp_next;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  lmtc_sync #(.W(GLOB_W)) u_glob_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({global_rx_high_z_control, global_standard_strap, global_standard_strap_enable}),
    .q(glob_s)
  );

  lmtc_sync #(.W(2*NUM_CH)) u_line_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({rx_ring_input, rx_tip_input}),
    .q(line_s)
  );

  // ----------------------------------------
  // per-channel decode
  // ----------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    lmtc_chan_if cif ();
    assign cif.chan_cfg = chan_cfg_reg[g];
    assign cif.rx_cfg = rx_cfg_reg[g];
    assign cif.strap_en = glob_s[PIN_STRAP_EN];
    assign cif.strap = glob_s[PIN_STRAP];
    assign cif.hz_ctl = glob_s[PIN_HIGH_Z];
    lmtc_chan_decode u_dec (
      .ch(cif)
    );
    assign dec_e1[g] = cif.e1;
    assign dec_single[g] = cif.single;
    assign dec_ring[g] = cif.ring_en;
    assign dec_high_z[g] = cif.high_z;
    assign dec_int[g] = cif.int_match;
    assign dec_full[g] = cif.fully_int;
    assign dec_res[2*g +: 2] = cif.res_code;
  end

  // ----------------------------------------
  // decoded outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_e1_reg <= '0;
      rx_single_reg <= '0;
      rx_high_z_reg <= '1;
      int_match_reg <= '0;
      fully_int_reg <= '0;
      res_code_reg <= '0;
    end else begin
      line_e1_reg <= dec_e1;
      rx_single_reg <= dec_single;
      rx_high_z_reg <= dec_high_z;
      int_match_reg <= dec_int;
      fully_int_reg <= dec_full;
      res_code_reg <= dec_res;
    end
  end

  // tip always passes, ring only in differential mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_tip_out_reg <= '0;
      rx_ring_out_reg <= '0;
    end else begin
      rx_tip_out_reg <= line_s[NUM_CH-1:0];
      rx_ring_out_reg <= line_s[2*NUM_CH-1:NUM_CH] & dec_ring;
    end
  end

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign do_write = aw_hold_reg && w_hold_reg;
  assign wr_region = aw_addr_reg[11:6];
  assign wr_ch = aw_addr_reg[5:2];
  assign wr_ok = (wr_region == REGION_CHAN) || (wr_region == REGION_RX);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_hold_reg <= 1'b0;
      w_byte_reg <= '0;
      w_lane_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      w_byte_reg <= s_axi_wdata[7:0];
      w_lane_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end
  end

  // per-channel configuration copies
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        chan_cfg_reg[i] <= CHAN_CFG_RST;
        rx_cfg_reg[i] <= RX_CFG_RST;
      end
    end else if (do_write && w_lane_reg) begin
      if (wr_region == REGION_CHAN) begin
        chan_cfg_reg[wr_ch] <= w_byte_reg;
      end else if (wr_region == REGION_RX) begin
        rx_cfg_reg[wr_ch] <= w_byte_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  assign s_axi_arready = !rvalid_reg;
  assign rd_region = s_axi_araddr[11:6];
  assign rd_ch = s_axi_araddr[5:2];

  always_comb begin
    rd_next = '0;
    rresp_next = RESP_OKAY;
    case (rd_region)
      REGION_CHAN: begin
        rd_next[7:0] = chan_cfg_reg[rd_ch];
      end
      REGION_RX: begin
        rd_next[7:0] = rx_cfg_reg[rd_ch];
      end
      REGION_STAT: begin
        rd_next[ST_E1] = line_e1_reg[rd_ch];
        rd_next[ST_SINGLE] = rx_single_reg[rd_ch];
        rd_next[ST_RING] = !rx_single_reg[rd_ch];
        rd_next[ST_HIGH_Z] = rx_high_z_reg[rd_ch];
        rd_next[ST_INT] = int_match_reg[rd_ch];
        rd_next[ST_FULL] = fully_int_reg[rd_ch];
        rd_next[ST_RES_LO +: 2] = res_code_reg[2*rd_ch +: 2];
      end
      default: begin
        rresp_next = RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_next;
      rresp_reg <= rresp_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  global_t1_a: assert property (
    glob_s[PIN_STRAP_EN] && glob_s[PIN_STRAP] |=> line_e1_reg == '0)
    else $error("open straps did not give T1/J1 on all channels");

  global_e1_a: assert property (
    glob_s[PIN_STRAP_EN] && !glob_s[PIN_STRAP] |=> &line_e1_reg)
    else $error("low strap did not give E1 on all channels");

  per_chan_std_a: assert property (
    !glob_s[PIN_STRAP_EN] |=> line_e1_reg[3] == $past(chan_cfg_reg[3][LINE_STD_BIT]))
    else $error("channel standard did not follow its bit");

  single_sel_a: assert property (
    rx_single_reg[5] == $past(rx_cfg_reg[5][SINGLE_BIT]))
    else $error("single-ended select did not follow bit 3");

  tip_only_a: assert property (
    (rx_single_reg & rx_ring_out_reg) == '0)
    else $error("ring level passed in single-ended mode");

  hz_force_a: assert property (
    !glob_s[PIN_HIGH_Z] |=> &rx_high_z_reg && (int_match_reg == '0) && (fully_int_reg == '0))
    else $error("low high-z pin did not force external matching");

  hz_pin_path_a: assert property (
    $fell(global_rx_high_z_control) ##1 !global_rx_high_z_control [*2] |=> &rx_high_z_reg)
    else $error("high-z pin did not reach receivers in three cycles");

  int_scheme_a: assert property (
    glob_s[PIN_HIGH_Z] && !rx_cfg_reg[0][TERM_TOP_BIT] |=>
      int_match_reg[0] && !rx_high_z_reg[0] &&
      (fully_int_reg[0] == !$past(rx_cfg_reg[0][SCHEME_BIT])))
    else $error("internal matching or scheme wrong");

  res_code_a: assert property (
    glob_s[PIN_HIGH_Z] && !rx_cfg_reg[7][TERM_TOP_BIT] |=>
      res_code_reg[15:14] == $past(rx_cfg_reg[7][1:0]))
    else $error("internal resistor code wrong");

  ext_only_a: assert property (
    glob_s[PIN_HIGH_Z] && rx_cfg_reg[1][TERM_TOP_BIT] |=>
      rx_high_z_reg[1] && !int_match_reg[1] && (res_code_reg[3:2] == RES_T1_100))
    else $error("external-only matching not applied");

  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  full_int_c: cover property (glob_s[PIN_HIGH_Z] ##1 fully_int_reg[0]);
  hz_force_c: cover property ($fell(glob_s[PIN_HIGH_Z]) ##1 &rx_high_z_reg);
  per_chan_e1_c: cover property (!glob_s[PIN_STRAP_EN] ##1 line_e1_reg[3]);
  write_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
endmodule

/* File: dv/lmtc_line_model.sv */
// lmtc_line_model: line side and hot-swap pin of the far side
// assumes: bench sets release and line pattern, one clock
`timescale 1ns/1ps
module lmtc_line_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bench control
  input wire logic hz_release,
  input wire logic [15:0] line_pattern,
  // pins
  output logic hz_ctl,
  output logic [15:0] tip,
  output logic [15:0] ring
);
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hz_ctl <= 1'b0;
      tip <= 16'h0000;
      ring <= 16'hFFFF;
    end else begin
      hz_ctl <= hz_release;
      tip <= line_pattern;
      ring <= ~line_pattern;
    end
  end
endmodule

/* File: dv/testbench.sv */
// testbench: axi4-lite access and pin stimulus for lmtc_top
// assumes: lmtc_pkg compiled first, far side from lmtc_line_model
`timescale 1ns/1ps
module testbench import lmtc_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] s_axi_awaddr = '0;
  logic [11:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [1:0] rs;
  logic strap_en = 1'b1;
  logic strap = 1'b1;
  logic hz_release = 1'b0;
  logic [15:0] line_pattern = 16'h0000;
  logic hz_ctl;
  logic [15:0] tip, ring, e1_o, single_o, hz_o, int_o, full_o, tip_o, ring_o;
  logic [31:0] res_o, exp_res;
  logic [15:0] exp_int, exp_full;
  int fail_count = 0;
  int comparisons = 0;

  always #50 clk = ~clk;

  lmtc_line_model lmtc_line_model_i (.clk(clk), .reset_n(reset_n), .hz_release(hz_release),
    .line_pattern(line_pattern), .hz_ctl(hz_ctl), .tip(tip), .ring(ring));

  lmtc_top lmtc_top_i (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .global_standard_strap_enable(strap_en), .global_standard_strap(strap),
    .global_rx_high_z_control(hz_ctl), .rx_tip_input(tip), .rx_ring_input(ring),
    .line_e1_reg(e1_o), .rx_single_reg(single_o), .rx_high_z_reg(hz_o),
    .int_match_reg(int_o), .fully_int_reg(full_o), .res_code_reg(res_o),
    .rx_tip_out_reg(tip_o), .rx_ring_out_reg(ring_o));

  // ----------------------------------------
  // report
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic timeout(input int n);
    if (n > 50) begin
      fail_count++;
      give_verdict();
    end
  endtask

  // ----------------------------------------
  // bus access
  // ----------------------------------------
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic a_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hs) begin
      @(negedge clk);
      a_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk);
      if (a_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (b_hs) s_axi_bready <= 1'b0;
      n++;
      timeout(n);
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic a_hs, r_hs;
    n = 0;
    r_hs = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_hs) begin
      @(negedge clk);
      a_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (a_hs) s_axi_arvalid <= 1'b0;
      if (r_hs) s_axi_rready <= 1'b0;
      n++;
      timeout(n);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axi_write(a, d, rs);
    check("write response", 32'(rs), 32'(RESP_OKAY));
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic pins(input logic en, input logic st, input logic [15:0] exp);
    @(posedge clk);
    strap_en <= en;
    strap <= st;
    settle();
    check("line standard", 32'(e1_o), 32'(exp));
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    @(posedge clk);
    @(negedge clk);
    check("high-z in reset", 32'(hz_o), 32'h0000FFFF);
    @(posedge clk);
    reset_n <= 1'b1;
    axi_read(CHAN_CFG_BASE + 12'h03C, rd, rs);
    check("channel config reset", rd, 32'(CHAN_CFG_RST));
    axi_read(RX_CFG_BASE + 12'h03C, rd, rs);
    check("termination reset", rd, 32'(RX_CFG_RST));
    axi_read(12'hFF0, rd, rs);
    check("unmapped read response", 32'(rs), 32'(RESP_SLVERR));
    check("unmapped read data", rd, 32'h00000000);
    axi_write(STATUS_BASE, 32'h000000FF, rs);
    check("status write response", 32'(rs), 32'(RESP_SLVERR));
    // hot-swap: internal matching written while the high-z pin is low
    for (int i = 0; i < 16; i++) wr(RX_CFG_BASE + 12'(4 * i), 32'h00000002);
    settle();
    check("forced high-z", 32'(hz_o), 32'h0000FFFF);
    check("forced no internal", 32'(int_o), 32'h00000000);
    @(posedge clk);
    hz_release <= 1'b1;
    settle();
    check("released high-z", 32'(hz_o), 32'h00000000);
    check("released resistor", res_o, 32'hAAAAAAAA);
    // lines are transformer-coupled, so fully internal matching is allowed
    exp_res = '0;
    exp_int = '0;
    exp_full = '0;
    for (int i = 0; i < 16; i++) begin
      if (i < 8) begin
        wr(RX_CFG_BASE + 12'(4 * i), 32'((i % 2) * 16 + i / 2));
        exp_res[2 * i +: 2] = 2'(i / 2);
        exp_int[i] = 1'b1;
        exp_full[i] = (i % 2 == 0);
      end else begin
        wr(RX_CFG_BASE + 12'(4 * i), 32'h00000017);
      end
    end
    settle();
    check("internal match", 32'(int_o), 32'(exp_int));
    check("fully internal", 32'(full_o), 32'(exp_full));
    check("resistor code", res_o, exp_res);
    check("external high-z", 32'(hz_o), 32'h0000FF00);
    axi_read(STATUS_BASE + 12'h018, rd, rs);
    check("status channel 6", rd, 32'h000000F4);
    // line standard, per channel copies against the global pins
    for (int i = 0; i < 16; i++) begin
      wr(CHAN_CFG_BASE + 12'(4 * i), {24'hABCDEF, 7'h00, 1'(16'hA5CB >> i)});
    end
    // masked write leaves channel 0 alone
    s_axi_wstrb <= 4'hE;
    wr(CHAN_CFG_BASE, 32'h00000000);
    s_axi_wstrb <= 4'hF;
    axi_read(CHAN_CFG_BASE, rd, rs);
    check("channel config readback", rd, 32'h00000001);
    pins(1'b1, 1'b1, 16'h0000);
    pins(1'b1, 1'b0, 16'hFFFF);
    pins(1'b0, 1'b0, 16'hA5CB);
    pins(1'b0, 1'b1, 16'hA5CB);
    // single-ended input on channel 5
    wr(RX_CFG_BASE + 12'h014, 32'h0000000C);
    @(posedge clk);
    line_pattern <= 16'h3C5A;
    settle();
    check("single-ended", 32'(single_o), 32'h00000020);
    check("tip out", 32'(tip_o), 32'h00003C5A);
    check("ring out", 32'(ring_o), 32'h0000C385);
    // hot-swap pin lowered again in mid-run
    @(posedge clk);
    hz_release <= 1'b0;
    settle();
    check("relowered high-z", 32'(hz_o), 32'h0000FFFF);
    check("relowered resistor", res_o, 32'h00000000);
    check("relowered fully internal", 32'(full_o), 32'h00000000);
    give_verdict();
  end
endmodule
